// ===== verilog/dpsr_top.sv
`timescale 1ns/1ps
module dpsr_top
  import dpsr_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET_N,
  // Device pins.
  input wire logic CHIP_POWERDOWN_PIN,
  input wire logic MCLK_IN,
  input wire logic FRAME_CLK_IN,
  input wire logic REGULATOR_ENABLE_PIN,
  // Register writes from the control port.
  input wire logic WR_EN,
  input wire logic [3:0] WR_PAIR_POWER_BITS,
  input wire logic WR_SOFT_RESET_BIT,
  input wire logic [5:0] WR_ZERO_CFG,
  input wire logic [3:0] LEFT_ZERO_SELECT_BITS_IN,
  input wire logic [3:0] RIGHT_ZERO_SELECT_BITS_IN,
  // Zero data detected by the data path.
  input wire logic ZERO_DATA_DET,
  // Status and control outputs.
  output logic [1:0] STATE,
  output logic [7:0] PAIR_OUT_MODE,
  output logic DIGITAL_RUN,
  output logic ANALOG_RUN,
  output logic REGULATOR_ON,
  output logic DIGITAL_RESET_N,
  output logic ZERO_DETECT_EN,
  output logic ZERO_FLAG_PIN,
  output logic [3:0] PAIR_POWER_BITS,
  output logic SOFT_RESET_BIT
);
  dpsr_if tk ();
  // Synchronisers and edge history.
  logic [1:0] pdn_s, mck_s, frm_s, reg_s;
  logic mck_d, frm_d;
  logic [7:0] stop_cnt;
  logic clk_ok;
  // Register copies.
  logic [3:0] pwr;
  logic srst, zf_pol, zf_opt;
  logic [7:0] zsel;
  logic srst_q, srst_d, zf;
  logic [1:0] zf_cnt;
  logic [3:0] pair_on;
  logic [7:0] next_stop_cnt;
  logic next_clk_ok, next_zf;
  logic [3:0] next_pwr;
  logic next_srst, next_zf_pol, next_zf_opt;
  logic [7:0] next_zsel;
  logic [1:0] next_zf_cnt;
  dpsr_state_t next_st;
  logic [7:0] next_mode;

  // Pin synchronisers feed edge detectors only from the second stage.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pdn_s <= 2'h0;
      mck_s <= 2'h0;
      frm_s <= 2'h0;
      reg_s <= 2'h0;
      mck_d <= 1'b0;
      frm_d <= 1'b0;
    end
    else
    begin
      pdn_s <= {pdn_s[0], CHIP_POWERDOWN_PIN};
      mck_s <= {mck_s[0], MCLK_IN};
      frm_s <= {frm_s[0], FRAME_CLK_IN};
      reg_s <= {reg_s[0], REGULATOR_ENABLE_PIN};
      mck_d <= mck_s[1];
      frm_d <= frm_s[1];
    end
  end

  // Clock-stop detector: no master clock edge for the stop time drops clk_ok.
  always_comb
  begin
    next_stop_cnt = stop_cnt;
    next_clk_ok = clk_ok;
    if (mck_s[1] != mck_d)
    begin
      next_stop_cnt = 8'h0;
      next_clk_ok = 1'b1;
    end
    else if (stop_cnt >= 8'(STOP_CYC - 1))
      next_clk_ok = 1'b0;
    else
      next_stop_cnt = stop_cnt + 8'h1;
  end

  // Control registers with defaults restored while the pin is low.
  always_comb
  begin
    next_pwr = pwr;
    next_srst = srst;
    next_zf_pol = zf_pol;
    next_zf_opt = zf_opt;
    next_zsel = zsel;
    if (!pdn_s[1])
    begin
      next_pwr = PWR_RESET;
      next_srst = SRST_RESET;
      next_zf_pol = 1'b0;
      next_zf_opt = 1'b0;
      next_zsel = 8'h0;
    end
    else if (WR_EN)
    begin
      next_pwr = WR_PAIR_POWER_BITS;
      next_srst = WR_SOFT_RESET_BIT;
      next_zf_pol = WR_ZERO_CFG[0];
      next_zf_opt = WR_ZERO_CFG[1];
      next_zsel = {LEFT_ZERO_SELECT_BITS_IN, RIGHT_ZERO_SELECT_BITS_IN};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      stop_cnt <= 8'h0;
      clk_ok <= 1'b0;
      pwr <= PWR_RESET;
      srst <= SRST_RESET;
      zf_pol <= 1'b0;
      zf_opt <= 1'b0;
      zsel <= 8'h0;
      srst_d <= 1'b0;
    end
    else
    begin
      stop_cnt <= next_stop_cnt;
      clk_ok <= next_clk_ok;
      pwr <= next_pwr;
      srst <= next_srst;
      zf_pol <= next_zf_pol;
      zf_opt <= next_zf_opt;
      zsel <= next_zsel;
      srst_d <= srst;
    end
  end

  // Sample tick from the frame clock rising edge.
  assign tk.fs_tick = frm_s[1] & ~frm_d;
  assign tk.clk_ok = clk_ok;

  // Per-pair power release: clear is immediate, set waits 2-3 ticks.
  genvar g;
  generate
    for (g = 0; g < NPAIR; g++)
    begin : g_pair
      dpsr_dly #(.DLY(PWR_UP_FS), .FAST_FALL(1'b1)) u_pwr (
        .clk(CLK),
        .reset_n(RESET_N),
        .tk(tk),
        .target(pwr[NPAIR - 1 - g] & pdn_s[1]),
        .q(pair_on[g])
      );
    end
  endgenerate

  // Internal soft reset follows the bit after 3-4 ticks either way.
  dpsr_dly #(.DLY(RST_DLY_FS), .FAST_FALL(1'b0)) u_rst (
    .clk(CLK),
    .reset_n(RESET_N),
    .tk(tk),
    .target(srst & pdn_s[1]),
    .q(srst_q)
  );

  // Overall state and per-pair output condition.
  always_comb
  begin
    next_mode = 8'h0;
    if (!pdn_s[1])
      next_st = ST_PDN;
    else if (!clk_ok || pwr == 4'h0)
      next_st = ST_STBY;
    else if (!srst_q)
      next_st = ST_RST;
    else
      next_st = ST_NORM;
    for (int i = 0; i < NPAIR; i++)
    begin
      if (next_st == ST_RST || next_st == ST_NORM)
      begin
        if (pair_on[i])
          next_mode[2*i +: 2] = srst_q ? OUT_SIG : OUT_MID;
        else
          next_mode[2*i +: 2] = OUT_HIZ;
      end
    end
  end

  // Zero flag: high on soft reset fall, low on the second tick after internal release.
  always_comb
  begin
    next_zf = zf;
    next_zf_cnt = zf_cnt;
    if (!pdn_s[1])
    begin
      next_zf = 1'b0;
      next_zf_cnt = 2'h0;
    end
    else if (!zf_pol && !zf_opt && zsel != 8'h0)
    begin
      if (srst_d && !srst)
      begin
        next_zf = 1'b1;
        next_zf_cnt = 2'h0;
      end
      else if (zf && srst && srst_q) // Waits for the bit and the internal reset to release.
      begin
        if (tk.fs_tick && zf_cnt == 2'(ZF_DLY_FS))
          next_zf = 1'b0;
        else if (tk.fs_tick)
          next_zf_cnt = zf_cnt + 2'h1;
      end
    end
  end

  // Output registers.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      zf <= 1'b0;
      zf_cnt <= 2'h0;
      STATE <= 2'h0;
      PAIR_OUT_MODE <= 8'h0;
      DIGITAL_RUN <= 1'b0;
      ANALOG_RUN <= 1'b0;
      REGULATOR_ON <= 1'b0;
      DIGITAL_RESET_N <= 1'b0;
      ZERO_DETECT_EN <= 1'b0;
      ZERO_FLAG_PIN <= 1'b0;
      PAIR_POWER_BITS <= PWR_RESET;
      SOFT_RESET_BIT <= SRST_RESET;
    end
    else
    begin
      zf <= next_zf;
      zf_cnt <= next_zf_cnt;
      STATE <= next_st;
      PAIR_OUT_MODE <= next_mode;
      DIGITAL_RUN <= (next_st == ST_NORM);
      ANALOG_RUN <= (next_st == ST_NORM || next_st == ST_RST);
      REGULATOR_ON <= pdn_s[1] & reg_s[1];
      DIGITAL_RESET_N <= srst_q;
      ZERO_DETECT_EN <= pdn_s[1] & clk_ok;
      ZERO_FLAG_PIN <= next_zf | (ZERO_DATA_DET & pdn_s[1] & clk_ok & srst_q);
      PAIR_POWER_BITS <= next_pwr;
      SOFT_RESET_BIT <= next_srst;
    end
  end

  // Clock stop forces standby and floating outputs within two cycles.
  AST_STOP_FLOAT: assert property (@(posedge CLK) disable iff (!RESET_N)
    $fell(clk_ok) |-> ##[1:2] (PAIR_OUT_MODE == 8'h0))
    else $error("outputs not floating after clock stop");
  AST_PDN_STATE: assert property (@(posedge CLK) disable iff (!RESET_N)
    !pdn_s[1] |=> (STATE == 2'h0 && PAIR_POWER_BITS == 4'h0))
    else $error("power down not applied");
  AST_PWR_FAST: assert property (@(posedge CLK) disable iff (!RESET_N)
    (pwr[3] == 1'b0) |=> (pair_on[0] == 1'b0))
    else $error("pair not off immediately");
  sequence dpsr_soft_fall;
    srst_d && !srst && pdn_s[1] && !zf_pol && !zf_opt && zsel != 8'h0;
  endsequence
  AST_ZF_RISE: assert property (@(posedge CLK) disable iff (!RESET_N)
    dpsr_soft_fall |=> ZERO_FLAG_PIN)
    else $error("zero flag not raised on soft reset fall");
endmodule

// ===== verilog/dpsr_pkg.sv
package dpsr_pkg;
  // System clock rate.
  localparam int CLK_HZ = 50000000;
  // Clock-stop detection time in nanoseconds, a least time rounded up.
  localparam int STOP_TIME_NS = 1000;
  localparam int STOP_CYC = (STOP_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Pair power-up release delay in sample periods.
  localparam int PWR_UP_FS = 2;
  // Soft reset assert and release delay in sample periods.
  localparam int RST_DLY_FS = 3;
  // Zero flag release delay after internal reset deasserts.
  localparam int ZF_DLY_FS = 1;
  // Number of DAC pairs.
  localparam int NPAIR = 4;
  // Analog output condition codes.
  localparam logic [1:0] OUT_HIZ = 2'h0;
  localparam logic [1:0] OUT_MID = 2'h1;
  localparam logic [1:0] OUT_SIG = 2'h2;
  // Reset values of the control bits.
  localparam logic [3:0] PWR_RESET = 4'h0;
  localparam logic SRST_RESET = 1'h0;
  // Operating state of the device.
  typedef enum logic [1:0] {ST_PDN, ST_STBY, ST_RST, ST_NORM} dpsr_state_t;
endpackage

// ===== verilog/dpsr_if.sv
`timescale 1ns/1ps
// Sample tick and clock-present level shared between the top and the delay counters.
interface dpsr_if;
  logic fs_tick;
  logic clk_ok;
  modport top (output fs_tick, output clk_ok);
  modport dly (input fs_tick, input clk_ok);
endinterface

// ===== verilog/dpsr_dly.sv
`timescale 1ns/1ps
// Delays a level change by DLY to DLY+1 sample ticks; a falling target may bypass.
module dpsr_dly
  import dpsr_pkg::*;
#(
  parameter int DLY = 3,
  parameter bit FAST_FALL = 1'b0
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Tick source and request level.
  dpsr_if.dly tk,
  input wire logic target,
  // Delayed level.
  output logic q
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic next_q;

  // Counts ticks while the target differs, then follows it.
  always_comb
  begin
    next_cnt = cnt;
    next_q = q;
    if (target == q)
      next_cnt = 3'h0;
    else if (FAST_FALL && !target)
      next_q = 1'b0;
    else if (tk.fs_tick && tk.clk_ok)
    begin
      if (cnt == 3'(DLY))
      begin
        next_q = target;
        next_cnt = 3'h0;
      end
      else
        next_cnt = cnt + 3'h1;
    end
  end

  // Registers the counter and output.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 3'h0;
      q <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      q <= next_q;
    end
  end

  // A fast fall lands at the next edge; otherwise only a sample tick moves the level.
  AST_DLY_FAST: assert property (@(posedge clk) disable iff (!reset_n)
    (FAST_FALL && !target) |=> !q)
    else $error("delayed level did not fall at once");
  AST_DLY_TICK: assert property (@(posedge clk) disable iff (!reset_n)
    (!tk.fs_tick && !(FAST_FALL && !target)) |=> $stable(q))
    else $error("delayed level moved without a sample tick");
endmodule

// ===== tb/dpsr_host.sv
`timescale 1ns/1ps
// Host side: master and frame clocks, control writes and zero data.
module dpsr_host
  import dpsr_pkg::*;
(
  // Clock and clock run request.
  input wire logic clk,
  input wire logic mclk_run,
  // Device side signals.
  output logic mclk,
  output logic frame_clk,
  output logic wr_en,
  output logic [3:0] wr_pwr,
  output logic wr_srst,
  output logic zero_data
);
  logic [3:0] div;

  // Idle values before the first edge.
  initial
  begin
    div = 4'h0;
    mclk = 1'b0;
    frame_clk = 1'b0;
    wr_en = 1'b0;
    wr_pwr = 4'h0;
    wr_srst = 1'b0;
  end

  // Both clocks stand still while stopped; one frame spans 16 cycles.
  always @(posedge clk)
  begin
    if (mclk_run)
    begin
      div <= div + 4'h1;
      mclk <= ~mclk;
      frame_clk <= div[3];
    end
  end

  // Silence is fed while the master clock is stopped.
  assign zero_data = ~mclk_run;

  // One write pulse, held for exactly one clock edge.
  task automatic wr(input logic [3:0] p, input logic s);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_pwr <= p;
    wr_srst <= s;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
endmodule

// ===== tb/dpsr_top_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the power, standby and reset controller.
module dpsr_top_bench;
  import dpsr_pkg::*;
  logic clk;
  logic reset_n = 1'b0;
  logic pd_pin = 1'b0;
  logic mclk_run = 1'b1;
  logic reg_en = 1'b1;
  logic mclk, frame, wr_en, wr_srst, zd;
  logic [3:0] wr_pwr;
  logic [1:0] state;
  logic [7:0] mode;
  logic drun, arun, reg_on, dig_rst_n, zd_en, zflag, srst_rb;
  logic [3:0] pwr_rb;
  int miscompares = 0;
  int tests_run = 0;

  dpsr_host dpsr_host_inst (.clk(clk), .mclk_run(mclk_run), .mclk(mclk), .frame_clk(frame),
    .wr_en(wr_en), .wr_pwr(wr_pwr), .wr_srst(wr_srst), .zero_data(zd));

  dpsr_top dpsr_top_inst (.CLK(clk), .RESET_N(reset_n), .CHIP_POWERDOWN_PIN(pd_pin),
    .MCLK_IN(mclk), .FRAME_CLK_IN(frame), .REGULATOR_ENABLE_PIN(reg_en), .WR_EN(wr_en),
    .WR_PAIR_POWER_BITS(wr_pwr), .WR_SOFT_RESET_BIT(wr_srst), .WR_ZERO_CFG(6'h00),
    .LEFT_ZERO_SELECT_BITS_IN(4'hf), .RIGHT_ZERO_SELECT_BITS_IN(4'hf), .ZERO_DATA_DET(zd),
    .STATE(state), .PAIR_OUT_MODE(mode), .DIGITAL_RUN(drun), .ANALOG_RUN(arun),
    .REGULATOR_ON(reg_on), .DIGITAL_RESET_N(dig_rst_n), .ZERO_DETECT_EN(zd_en),
    .ZERO_FLAG_PIN(zflag), .PAIR_POWER_BITS(pwr_rb), .SOFT_RESET_BIT(srst_rb));

  // System clock at 50 MHz.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Waits whole cycles, then lets the edge's updates settle.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Compares one result and counts it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected output conditions: bit 3 powers pair 0 in the low field.
  function automatic logic [7:0] exp_modes(input logic [3:0] p, input logic [1:0] m);
    for (int i = 0; i < NPAIR; i++)
      exp_modes[2*i +: 2] = p[3-i] ? m : OUT_HIZ;
  endfunction

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A power pattern runs as signal, then drives mid level under soft reset.
  task automatic t_pattern(input logic [3:0] p);
    dpsr_host_inst.wr(p, 1'b1);
    cyc(2);
    chk(8'(pwr_rb), 8'(p));
    cyc(80);
    chk(mode, exp_modes(p, OUT_SIG));
    chk(8'(state), 8'(ST_NORM));
    dpsr_host_inst.wr(p, 1'b0);
    cyc(84);
    chk(mode, exp_modes(p, OUT_MID));
    chk(8'({state, arun, drun}), 8'({ST_RST, 2'b10}));
  endtask

  // Clearing power floats at once; setting it again waits two to three ticks.
  task automatic t_power();
    dpsr_host_inst.wr(4'hf, 1'b1);
    cyc(96);
    dpsr_host_inst.wr(4'h0, 1'b1);
    cyc(2);
    chk(mode, 8'h00);
    chk(8'({state, reg_on, drun, arun}), 8'({ST_STBY, 3'b100}));
    chk(8'(zd_en), 8'h01);
    @(posedge clk) reg_en <= 1'b0;
    cyc(4);
    chk(8'(reg_on), 8'h00);
    @(posedge clk) reg_en <= 1'b1;
    dpsr_host_inst.wr(4'h8, 1'b1);
    cyc(28);
    chk(mode, 8'h00);
    cyc(36);
    chk(mode, exp_modes(4'h8, OUT_SIG));
  endtask

  // Master clock stop enters standby after 50 cycles and leaves on return.
  task automatic t_clk_stop();
    @(posedge clk) mclk_run <= 1'b0;
    cyc(40);
    chk(8'(state), 8'(ST_NORM));
    cyc(20);
    chk(8'({state, reg_on, drun, arun}), 8'({ST_STBY, 3'b100}));
    chk(mode, 8'h00);
    chk(8'(zd_en), 8'h00);
    chk(8'(zflag), 8'h00);
    @(posedge clk) mclk_run <= 1'b1;
    cyc(100);
    chk(8'(state), 8'(ST_NORM));
    chk(mode, exp_modes(4'h8, OUT_SIG));
  endtask

  // Soft reset delays and the zero flag around it.
  task automatic t_soft_rst();
    dpsr_host_inst.wr(4'hf, 1'b1);
    cyc(100);
    dpsr_host_inst.wr(4'hf, 1'b0);
    cyc(3);
    chk(8'({zflag, dig_rst_n}), 8'h03);
    cyc(80);
    chk(8'(dig_rst_n), 8'h00);
    chk(8'({pwr_rb, srst_rb}), 8'h1e);
    dpsr_host_inst.wr(4'hf, 1'b1);
    cyc(30);
    chk(8'({zflag, dig_rst_n}), 8'h02);
    cyc(50);
    chk(8'(dig_rst_n), 8'h01);
    cyc(60);
    chk(8'(zflag), 8'h00);
  endtask

  // Pin low stops everything, restores defaults and refuses writes.
  task automatic t_pin_low();
    @(posedge clk) pd_pin <= 1'b0;
    cyc(6);
    chk({state, mode[5:0]}, 8'h00);
    chk(8'({pwr_rb, srst_rb}), 8'h00);
    dpsr_host_inst.wr(4'hf, 1'b1);
    cyc(3);
    chk(8'({pwr_rb, srst_rb, zflag}), 8'h00);
  endtask

  // Main sequence.
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    cyc(4);
    chk({state, mode[5:0]}, 8'h00);
    chk(8'({pwr_rb, srst_rb}), 8'h00);
    @(posedge clk) pd_pin <= 1'b1;
    cyc(4);
    t_pattern(4'h8);
    t_pattern(4'h1);
    t_pattern(4'hf);
    t_power();
    t_clk_stop();
    t_soft_rst();
    t_pin_low();
    wrap_up();
  end

  // Watchdog cuts a hang short.
  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule
